// [rsi_pkg.sv]
// Purpose: constants and types shared by the reset state initialiser
// Assumes: 32-bit apb, 8-bit core registers
// Notes: offsets are byte addresses of aligned words
package rsi_pkg;
	// ************************************************
	// register offsets
	// ************************************************
	localparam logic [7:0] RSI_OFS_FLAGS = 8'h00;
	localparam logic [7:0] RSI_OFS_EVT_STAT = 8'h04;
	localparam logic [7:0] RSI_OFS_EVT_MASK = 8'h08;
	localparam logic [7:0] RSI_OFS_WDT_CTRL = 8'h0c;
	localparam logic [7:0] RSI_OFS_LV_SEL = 8'h10;
	localparam logic [7:0] RSI_OFS_PA_DATA = 8'h14;
	localparam logic [7:0] RSI_OFS_PA_DIR = 8'h18;
	localparam logic [7:0] RSI_OFS_TM0_HIGH = 8'h1c;
	localparam logic [7:0] RSI_OFS_INT_EN = 8'h20;
	localparam logic [7:0] RSI_OFS_TM_ON = 8'h24;
	localparam logic [7:0] RSI_OFS_ANA_SEL = 8'h28;
	localparam logic [7:0] RSI_OFS_CORE = 8'h2c;

	// ************************************************
	// values after reset
	// ************************************************
	localparam logic [7:0] RSI_WDT_CTRL_DEF = 8'h53;
	localparam logic [7:0] RSI_LV_SEL_DEF = 8'h55;
	localparam logic [7:0] RSI_PA_DATA_DEF = 8'hff;
	localparam logic [7:0] RSI_PA_DIR_DEF = 8'hff;
	localparam logic [7:0] RSI_TM0_HIGH_DEF = 8'h00;
	localparam logic [7:0] RSI_INT_EN_DEF = 8'h00;
	localparam logic [3:0] RSI_TM_ON_DEF = 4'h0;
	localparam logic [3:0] RSI_ANA_SEL_DEF = 4'hf;
	localparam logic [2:0] RSI_STACK_TOP = 3'h7;
	localparam logic [2:0] RSI_STACK_ZERO = 3'h0;
	localparam logic [7:0] RSI_TM0_HIGH_KEEP = 8'h0f;

	// ************************************************
	// settle counts in system clock cycles
	// ************************************************
	localparam logic [4:0] RSI_SETTLE_FAST = 5'h10;
	localparam logic [4:0] RSI_SETTLE_SLOW = 5'h02;

	// event status bit positions
	localparam int RSI_EV_POR = 0;
	localparam int RSI_EV_LVR = 1;
	localparam int RSI_EV_WDT_RUN = 2;
	localparam int RSI_EV_WDT_LP = 3;

	// core operating mode
	typedef enum logic [1:0] {
		RSI_MODE_NORMAL = 2'h0,
		RSI_MODE_SLOW = 2'h1,
		RSI_MODE_IDLE = 2'h2,
		RSI_MODE_DEEP_HALT = 2'h3
	} rsi_mode_t;
endpackage

// [rsi_settle_if.sv]
// Purpose: link between the initialiser and its settle timer
// Assumes: single clock domain
// Notes: start is a one-cycle pulse
`timescale 1ns/100ps
interface rsi_settle_if;
	logic start;
	logic fast;
	logic busy;
	logic done;
	modport ctl (output start, output fast, input busy, input done);
	modport tmr (input start, input fast, output busy, output done);
endinterface

// [rsi_settle.sv]
// Purpose: wake settle timer after a low-power time-out
// Assumes: fast selects the fast internal oscillator count
// Notes: busy from start until done pulse; counts below two are not supported
`timescale 1ns/100ps
module rsi_settle (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control side
	rsi_settle_if.tmr sif
);
	import rsi_pkg::*;

	typedef enum logic [1:0] {
		RSI_ST_IDLE = 2'b00,
		RSI_ST_COUNT = 2'b01
	} rsi_st_t;

	typedef struct packed {
		rsi_st_t st;
		logic [4:0] cnt;
		logic busy;
		logic done;
	} rsi_settle_st_t;

	rsi_settle_st_t s_r, s_nxt;

	// count down the settle time, one cycle per clock; the count is loaded
	// on the edge that takes the time-out, so the hold spans exactly the count
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
			RSI_ST_IDLE: begin
				if (sif.start) begin
					// (RQ2) fast osc count
					// (RQ3) slow osc count
					s_nxt.cnt = sif.fast ? RSI_SETTLE_FAST : RSI_SETTLE_SLOW;
					s_nxt.busy = 1'b1;
					s_nxt.st = RSI_ST_COUNT;
				end
			end
			RSI_ST_COUNT: begin
				s_nxt.cnt = s_r.cnt - 5'h01;
				// done one edge early: the initialiser drops core_hold on the next
				if (s_r.cnt == 5'h02) begin
					s_nxt.busy = 1'b0;
					s_nxt.done = 1'b1;
					s_nxt.st = RSI_ST_IDLE;
				end
			end
			default: begin
				s_nxt.st = RSI_ST_IDLE;
				s_nxt.busy = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sif.busy = s_r.busy;
	assign sif.done = s_r.done;
endmodule

// [rsi_top.sv]
// Purpose: reset state initialiser for a small 8-bit core
// Assumes: presetn is the power-on reset; other sources arrive as pulses
// Notes: registers reached over apb with one wait state
`timescale 1ns/100ps

// Function
// (RQ1) sleep time-out clears only pc and stack
// (RQ2) fast osc wake settle 16 cycles
// (RQ3) slow osc wake settle 2 cycles
// (RQ4) power-on clears both reset flags
// (RQ5) low-voltage reset keeps both flags
// (RQ6) running time-out sets timeout flag only
// (RQ7) low-power time-out sets both flags
// (RQ8) power-on disables every interrupt source
// (RQ9) power-on clears watchdog, counting restarts
// (RQ10) power-on switches all timers off
// (RQ11) power-on: pins input, analog pins converter
// (RQ12) power-on sets stack to top
// (RQ13) defaults loaded; low-power keeps, trims timer high
// (RQ14) running time-out acts like low-voltage reset
// (RQ15) unknown-after-reset registers left undriven
module rsi_top (
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// reset sources and core status
	input wire logic lowvolt_reset,
	input wire logic wdt_timeout,
	input wire rsi_pkg::rsi_mode_t core_mode,
	input wire logic fast_internal_osc,
	// core state controls
	output logic pc_clear,
	output logic [2:0] stack_ptr,
	output logic core_hold,
	output logic wdt_clear,
	output logic timeout_flag,
	output logic powerdown_flag,
	// register images
	output logic [7:0] watchdog_control,
	output logic [7:0] lowvolt_select,
	output logic [7:0] port_a_data,
	output logic [7:0] port_a_direction,
	output logic [7:0] timer0_count_high,
	output logic [7:0] int_enable,
	output logic [3:0] timer_enable,
	output logic [3:0] analog_input_pins,
	// interrupt
	output logic irq
);
	import rsi_pkg::*;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic pc_clear;
		logic [2:0] stack_ptr;
		logic core_hold;
		logic wdt_clear;
		logic timeout_flag;
		logic powerdown_flag;
		logic [7:0] wdt_ctrl;
		logic [7:0] lv_sel;
		logic [7:0] pa_data;
		logic [7:0] pa_dir;
		logic [7:0] tm0_high;
		logic [7:0] int_en;
		logic [3:0] tm_on;
		logic [3:0] ana_sel;
		logic [3:0] evt_stat;
		logic [3:0] evt_mask;
		logic irq;
	} rsi_state_t;

	rsi_state_t s_r, s_nxt;
	rsi_settle_if sif ();

	logic low_power;
	logic full_reset;
	logic lp_timeout;
	logic acc;
	logic wr;
	logic [3:0] evt_set;
	logic hit;

	// ************************************************
	// settle timer
	// ************************************************
	rsi_settle u_settle (
		.pclk(pclk),
		.presetn(presetn),
		.sif(sif)
	);
	// the count starts on the edge that takes the time-out, so the hold
	// spans exactly the settle time; a request while counting is dropped
	assign sif.start = lp_timeout && !sif.busy;
	assign sif.fast = fast_internal_osc;

	// ************************************************
	// reset source decode
	// ************************************************
	// low voltage wins over a time-out in the same cycle
	assign low_power = (core_mode == RSI_MODE_IDLE) || (core_mode == RSI_MODE_DEEP_HALT);
	assign full_reset = lowvolt_reset || (wdt_timeout && !low_power);
	assign lp_timeout = wdt_timeout && low_power && !lowvolt_reset;
	// apb access completes on the second access cycle
	assign acc = psel && penable && s_r.pready;
	assign wr = acc && pwrite;
	assign evt_set = {lp_timeout, wdt_timeout && !low_power && !lowvolt_reset,
		lowvolt_reset, 1'b0};

	// ************************************************
	// address decode
	// ************************************************
	// one map for the error answer, so a refused write never depends
	// on which case arm happens to miss
	always_comb begin
		case (paddr)
			RSI_OFS_FLAGS,
			RSI_OFS_EVT_STAT,
			RSI_OFS_EVT_MASK,
			RSI_OFS_WDT_CTRL,
			RSI_OFS_LV_SEL,
			RSI_OFS_PA_DATA,
			RSI_OFS_PA_DIR,
			RSI_OFS_TM0_HIGH,
			RSI_OFS_INT_EN,
			RSI_OFS_TM_ON,
			RSI_OFS_ANA_SEL,
			RSI_OFS_CORE: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.pc_clear = 1'b0;
		s_nxt.wdt_clear = 1'b0;
		s_nxt.pready = psel && penable && !s_r.pready;
		s_nxt.pslverr = 1'b0;
		s_nxt.prdata = 32'h0000_0000;

		// software writes first, reset events below override them
		if (wr) begin
			case (paddr)
				RSI_OFS_FLAGS: begin
					s_nxt.timeout_flag = pwdata[0];
					s_nxt.powerdown_flag = pwdata[1];
				end
				RSI_OFS_EVT_STAT: s_nxt.evt_stat = s_r.evt_stat & ~pwdata[3:0];
				RSI_OFS_EVT_MASK: s_nxt.evt_mask = pwdata[3:0];
				RSI_OFS_WDT_CTRL: s_nxt.wdt_ctrl = pwdata[7:0];
				RSI_OFS_LV_SEL: s_nxt.lv_sel = pwdata[7:0];
				RSI_OFS_PA_DATA: s_nxt.pa_data = pwdata[7:0];
				RSI_OFS_PA_DIR: s_nxt.pa_dir = pwdata[7:0];
				RSI_OFS_TM0_HIGH: s_nxt.tm0_high = pwdata[7:0];
				RSI_OFS_INT_EN: s_nxt.int_en = pwdata[7:0];
				RSI_OFS_TM_ON: s_nxt.tm_on = pwdata[3:0];
				RSI_OFS_ANA_SEL: s_nxt.ana_sel = pwdata[3:0];
				RSI_OFS_CORE: begin
				end
				// unmapped: refused in the answer formed below
				default: begin
				end
			endcase
		end

		// answer formed one cycle before pready, so it stands with pready
		if (psel && penable && !s_r.pready) begin
			case (paddr)
				RSI_OFS_FLAGS: s_nxt.prdata = {30'h0, s_r.powerdown_flag, s_r.timeout_flag};
				RSI_OFS_EVT_STAT: s_nxt.prdata = {28'h0, s_r.evt_stat};
				RSI_OFS_EVT_MASK: s_nxt.prdata = {28'h0, s_r.evt_mask};
				RSI_OFS_WDT_CTRL: s_nxt.prdata = {24'h0, s_r.wdt_ctrl};
				RSI_OFS_LV_SEL: s_nxt.prdata = {24'h0, s_r.lv_sel};
				RSI_OFS_PA_DATA: s_nxt.prdata = {24'h0, s_r.pa_data};
				RSI_OFS_PA_DIR: s_nxt.prdata = {24'h0, s_r.pa_dir};
				RSI_OFS_TM0_HIGH: s_nxt.prdata = {24'h0, s_r.tm0_high};
				RSI_OFS_INT_EN: s_nxt.prdata = {24'h0, s_r.int_en};
				RSI_OFS_TM_ON: s_nxt.prdata = {28'h0, s_r.tm_on};
				RSI_OFS_ANA_SEL: s_nxt.prdata = {28'h0, s_r.ana_sel};
				RSI_OFS_CORE: s_nxt.prdata = {27'h0, s_r.core_hold, 1'b0, s_r.stack_ptr};
				default: s_nxt.prdata = 32'h0000_0000;
			endcase
			// a write shows no data; only an unmapped write is refused
			if (pwrite) begin
				s_nxt.prdata = 32'h0000_0000;
				s_nxt.pslverr = !hit;
			end
		end

		// full reset from low voltage or a running time-out
		if (full_reset) begin
			// (RQ14) same load as low voltage
			// (RQ13) documented defaults
			s_nxt.wdt_ctrl = RSI_WDT_CTRL_DEF;
			s_nxt.lv_sel = RSI_LV_SEL_DEF;
			s_nxt.pa_data = RSI_PA_DATA_DEF;
			s_nxt.pa_dir = RSI_PA_DIR_DEF;
			s_nxt.tm0_high = RSI_TM0_HIGH_DEF;
			s_nxt.int_en = RSI_INT_EN_DEF;
			s_nxt.tm_on = RSI_TM_ON_DEF;
			s_nxt.ana_sel = RSI_ANA_SEL_DEF;
			s_nxt.stack_ptr = RSI_STACK_TOP;
			s_nxt.pc_clear = 1'b1;
			s_nxt.wdt_clear = 1'b1;
			s_nxt.core_hold = 1'b0;
			if (!lowvolt_reset) begin
				// (RQ6) timeout flag set, powerdown kept
				s_nxt.timeout_flag = 1'b1;
			end
			// (RQ5) low voltage keeps both flags
			if (lowvolt_reset) begin
				s_nxt.timeout_flag = s_r.timeout_flag;
				s_nxt.powerdown_flag = s_r.powerdown_flag;
			end
		end else if (lp_timeout) begin
			// (RQ1) only pc and stack cleared
			s_nxt.pc_clear = 1'b1;
			s_nxt.stack_ptr = RSI_STACK_ZERO;
			// (RQ13) keep contents, trim timer high nibble
			s_nxt.tm0_high = s_r.tm0_high & RSI_TM0_HIGH_KEEP;
			// (RQ7) both flags set
			s_nxt.timeout_flag = 1'b1;
			s_nxt.powerdown_flag = 1'b1;
			// (RQ2) hold the core for the settle time
			s_nxt.core_hold = 1'b1;
		end else if (sif.done) begin
			// done arrives one edge early, so the hold ends on time
			s_nxt.core_hold = 1'b0;
		end

		// sticky events; a new event beats a clear in the same cycle
		s_nxt.evt_stat = s_nxt.evt_stat | evt_set;
		s_nxt.irq = |(s_nxt.evt_stat & s_nxt.evt_mask);
	end

	// ************************************************
	// state register
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			// (RQ4) both flags cleared
			s_r.timeout_flag <= 1'b0;
			s_r.powerdown_flag <= 1'b0;
			// (RQ8) interrupts disabled
			s_r.int_en <= RSI_INT_EN_DEF;
			// (RQ9) watchdog cleared, restarts next edge
			s_r.wdt_clear <= 1'b1;
			// (RQ10) timers off
			s_r.tm_on <= RSI_TM_ON_DEF;
			// (RQ11) pins input, analog function selected
			s_r.pa_dir <= RSI_PA_DIR_DEF;
			s_r.pa_data <= RSI_PA_DATA_DEF;
			s_r.ana_sel <= RSI_ANA_SEL_DEF;
			// (RQ12) stack at top
			s_r.stack_ptr <= RSI_STACK_TOP;
			// (RQ13) power-on defaults
			s_r.wdt_ctrl <= RSI_WDT_CTRL_DEF;
			s_r.lv_sel <= RSI_LV_SEL_DEF;
			s_r.tm0_high <= RSI_TM0_HIGH_DEF;
			s_r.pc_clear <= 1'b1;
			s_r.evt_stat <= 4'h1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ************************************************
	// outputs, all straight from the state register
	// ************************************************
	// (RQ15) no register of unknown content is modelled
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign pc_clear = s_r.pc_clear;
	assign stack_ptr = s_r.stack_ptr;
	assign core_hold = s_r.core_hold;
	assign wdt_clear = s_r.wdt_clear;
	assign timeout_flag = s_r.timeout_flag;
	assign powerdown_flag = s_r.powerdown_flag;
	assign watchdog_control = s_r.wdt_ctrl;
	assign lowvolt_select = s_r.lv_sel;
	assign port_a_data = s_r.pa_data;
	assign port_a_direction = s_r.pa_dir;
	assign timer0_count_high = s_r.tm0_high;
	assign int_enable = s_r.int_en;
	assign timer_enable = s_r.tm_on;
	assign analog_input_pins = s_r.ana_sel;
	assign irq = s_r.irq;
endmodule

// [rsi_checker.sv]
// Purpose: port-level checks of the reset state initialiser
// Assumes: one clock, presetn active low and asynchronous
// Notes: apb timing is judged by the bench, not here
`timescale 1ns/100ps
module rsi_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// reset sources and core status
	input wire logic lowvolt_reset,
	input wire logic wdt_timeout,
	input wire rsi_pkg::rsi_mode_t core_mode,
	input wire logic fast_internal_osc,
	// core state and register images
	input wire logic pc_clear,
	input wire logic [2:0] stack_ptr,
	input wire logic core_hold,
	input wire logic wdt_clear,
	input wire logic timeout_flag,
	input wire logic powerdown_flag,
	input wire logic [7:0] watchdog_control,
	input wire logic [7:0] lowvolt_select,
	input wire logic [7:0] timer0_count_high
);
	import rsi_pkg::*;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ****************************************
	// event decode
	// ****************************************
	// a low-voltage event wins over a time-out in the same cycle
	logic lp_to;
	logic run_to;
	assign lp_to = wdt_timeout && !lowvolt_reset && core_mode[1];
	assign run_to = wdt_timeout && !lowvolt_reset && !core_mode[1];
	// ****************************************
	// settle sequences, hold counted from the first held cycle
	// ****************************************
	sequence s_fast_settle;
		core_hold ##15 core_hold ##1 !core_hold;
	endsequence
	sequence s_slow_settle;
		core_hold ##1 core_hold ##1 !core_hold;
	endsequence
	// a settle already running is not restarted, so only fresh ones
	a_fast_settle: assert property (lp_to && fast_internal_osc && !core_hold
		|=> s_fast_settle) else $error("fast settle length wrong");
	a_slow_settle: assert property (lp_to && !fast_internal_osc && !core_hold
		|=> s_slow_settle) else $error("slow settle length wrong");
	a_lp_core_clear: assert property (lp_to |=> pc_clear && stack_ptr == 3'h0
		&& timeout_flag && powerdown_flag) else $error("low-power time-out state wrong");
	a_lp_regs_kept: assert property (lp_to |=> watchdog_control == $past(watchdog_control)
		&& timer0_count_high == ($past(timer0_count_high) & 8'h0f))
		else $error("low-power time-out changed registers");
	a_lv_flags_kept: assert property (lowvolt_reset
		|=> $stable(timeout_flag) && $stable(powerdown_flag)) else $error("flags moved");
	a_run_to_flags: assert property (run_to |=> timeout_flag && $stable(powerdown_flag))
		else $error("running time-out flags wrong");
	a_full_defaults: assert property (lowvolt_reset || run_to
		|=> watchdog_control == 8'h53 && lowvolt_select == 8'h55 && stack_ptr == 3'h7
		&& pc_clear) else $error("full reset defaults wrong");
	a_wdt_restart: assert property ($rose(wdt_clear)
		|-> ($past(lowvolt_reset) || $past(run_to)) ##1 !wdt_clear)
		else $error("watchdog clear pulse wrong");
endmodule

bind rsi_top rsi_checker chk (.*);

// [rsi_top_tb.sv]
// Purpose: self-checking bench for the reset state initialiser
// Assumes: apb slave answers in its own time; events are one-cycle pulses
// Notes: each scenario task judges its own results
`timescale 1ns/100ps
module rsi_top_tb;
	import rsi_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic lowvolt_reset = 1'b0;
	logic wdt_timeout = 1'b0;
	rsi_mode_t core_mode = RSI_MODE_NORMAL;
	logic fast_internal_osc = 1'b1;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, rerr, pc_clear, core_hold, wdt_clear, timeout_flag, powerdown_flag, irq;
	logic [2:0] stack_ptr;
	logic [7:0] watchdog_control, lowvolt_select, port_a_data, port_a_direction;
	logic [7:0] timer0_count_high, int_enable;
	logic [3:0] timer_enable, analog_input_pins;
	int n_mismatch = 0;
	int checked = 0;

	// 10 MHz clock
	always #50 pclk = ~pclk;

	rsi_top dut (.*);

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask

	// let one edge land, then look
	task automatic settle();
		@(posedge pclk);
		#1;
	endtask

	// pulse one event; returns once its effect is visible
	task automatic ev(input logic lv, input logic to, input rsi_mode_t m);
		@(posedge pclk);
		lowvolt_reset <= lv;
		wdt_timeout <= to;
		core_mode <= m;
		@(posedge pclk);
		lowvolt_reset <= 1'b0;
		wdt_timeout <= 1'b0;
		// look while the one-cycle pulses still stand
		#1;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_por();
		rc(RSI_OFS_FLAGS, 32'h0);
		rc(RSI_OFS_INT_EN, 32'h0);
		rc(RSI_OFS_TM_ON, 32'h0);
		rc(RSI_OFS_ANA_SEL, 32'hf);
		rc(RSI_OFS_PA_DIR, 32'hff);
		rc(RSI_OFS_CORE, 32'h7);
		rc(RSI_OFS_WDT_CTRL, 32'h53);
		rc(RSI_OFS_LV_SEL, 32'h55);
		rc(RSI_OFS_PA_DATA, 32'hff);
		rc(RSI_OFS_TM0_HIGH, 32'h0);
	endtask

	// unmapped place and the read-only core word
	task automatic t_bus();
		apb(1'b1, 8'h30, 32'h1);
		chk(rerr, 1'b1);
		apb(1'b0, 8'h30, 32'h0);
		chk(rdat, 32'h0);
		wr(RSI_OFS_CORE, 32'h0);
		rc(RSI_OFS_CORE, 32'h7);
	endtask

	// low voltage (to=0) or running time-out (to=1)
	task automatic t_full(input logic to, input rsi_mode_t m);
		wr(RSI_OFS_FLAGS, {30'h0, 1'b1, !to});
		wr(RSI_OFS_WDT_CTRL, 32'h3c);
		wr(RSI_OFS_PA_DIR, 32'h0f);
		wr(RSI_OFS_INT_EN, 32'h81);
		wr(RSI_OFS_TM_ON, 32'h5);
		ev(!to, to, m);
		chk({timeout_flag, powerdown_flag}, 2'b11);
		chk({pc_clear, wdt_clear, stack_ptr}, 5'h1f);
		chk({watchdog_control, port_a_direction, int_enable}, 24'h53ff00);
		chk(timer_enable, 4'h0);
		settle();
		chk({pc_clear, wdt_clear}, 2'b00);
	endtask

	// time-out while idle or in deep halt, then the settle hold
	task automatic t_lp(input logic fast, input rsi_mode_t m);
		int n;
		n = 0;
		@(posedge pclk);
		fast_internal_osc <= fast;
		wr(RSI_OFS_FLAGS, 32'h0);
		wr(RSI_OFS_WDT_CTRL, 32'h3c);
		wr(RSI_OFS_TM0_HIGH, 32'ha5);
		ev(1'b0, 1'b1, m);
		chk({pc_clear, stack_ptr, core_hold}, 5'h11);
		chk({timeout_flag, powerdown_flag}, 2'b11);
		chk({watchdog_control, timer0_count_high}, 16'h3c05);
		while (core_hold === 1'b1 && n < 40) begin
			settle();
			n++;
		end
		chk(n, fast ? 16 : 2);
	endtask

	// sticky status, mask and write-one-to-clear
	task automatic t_irq();
		wr(RSI_OFS_EVT_STAT, 32'hf);
		wr(RSI_OFS_EVT_MASK, 32'h2);
		rc(RSI_OFS_EVT_STAT, 32'h0);
		ev(1'b0, 1'b1, RSI_MODE_NORMAL);
		settle();
		chk(irq, 1'b0);
		ev(1'b1, 1'b0, RSI_MODE_NORMAL);
		settle();
		chk(irq, 1'b1);
		rc(RSI_OFS_EVT_STAT, 32'h6);
		wr(RSI_OFS_EVT_STAT, 32'h2);
		settle();
		chk(irq, 1'b0);
		rc(RSI_OFS_EVT_STAT, 32'h4);
	endtask

	// power-on again in mid-run after software moved flags and enables
	task automatic t_rst();
		wr(RSI_OFS_FLAGS, 32'h3);
		wr(RSI_OFS_INT_EN, 32'h81);
		wr(RSI_OFS_TM_ON, 32'h5);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({pc_clear, wdt_clear}, 2'b11);
		presetn <= 1'b1;
		t_por();
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge pclk);
		chk({pc_clear, wdt_clear}, 2'b11);
		presetn <= 1'b1;
		t_por();
		t_bus();
		t_full(1'b0, RSI_MODE_NORMAL);
		t_full(1'b1, RSI_MODE_SLOW);
		t_lp(1'b1, RSI_MODE_DEEP_HALT);
		t_lp(1'b0, RSI_MODE_IDLE);
		t_irq();
		t_rst();
		end_sim();
	end

	// hang guard, several times the few hundred cycles the run needs
	initial begin
		repeat (3000) @(posedge pclk);
		n_mismatch++;
		end_sim();
	end
endmodule
